//--- design/ifeb_consts.svh
// register offsets, field positions and reset values of the interrupt flag bank
`ifndef IFEB_CONSTS_SVH
`define IFEB_CONSTS_SVH
`define IFEB_OFF_EDGE 12'h000
`define IFEB_OFF_CTL0 12'h004
`define IFEB_OFF_CTL1 12'h008
`define IFEB_OFF_GRP0 12'h00C
`define IFEB_OFF_GRP1 12'h010
`define IFEB_OFF_EVST 12'h014
`define IFEB_OFF_EVEN 12'h018
`define IFEB_OFF_EVCLR 12'h01C
`define IFEB_OFF_VARIANT 12'h020
`define IFEB_RST_BYTE 8'h00
`define IFEB_EDGE_MASK 8'h0F
`define IFEB_CTL0_MASK 8'h7F
`define IFEB_CTL1_MASK 8'hDD
`define IFEB_GRP0_MASK 8'h33
`define IFEB_GRP1_MASK 8'h77
`define IFEB_C0_EMI 0
`define IFEB_C0_PA_EN 1
`define IFEB_C0_PB_EN 2
`define IFEB_C0_G0_EN 3
`define IFEB_C0_PA_FL 4
`define IFEB_C0_PB_FL 5
`define IFEB_C0_G0_FL 6
`define IFEB_C1_G1_EN 0
`define IFEB_C1_TB_EN 2
`define IFEB_C1_LV_EN 3
`define IFEB_C1_G1_FL 4
`define IFEB_C1_TB_FL 6
`define IFEB_C1_LV_FL 7
`define IFEB_NUM_EVT 8
`endif

//--- design/ifeb_pkg.sv
// types shared by the interrupt flag bank
package ifeb_pkg;
    typedef enum logic [3:0] {
        IFEB_EDGE_OFF = 4'b0001,
        IFEB_EDGE_RISE = 4'b0010,
        IFEB_EDGE_FALL = 4'b0100,
        IFEB_EDGE_BOTH = 4'b1000
    } ifeb_edge_t;
    typedef logic [7:0] ifeb_byte_t;
endpackage : ifeb_pkg

//--- design/ifeb_edge_det.sv
// edge detector for one external interrupt pin
`timescale 1ns/1ps
module ifeb_edge_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic [1:0] sel,
    output logic hit
);
    import ifeb_pkg::*;
    logic prev_reg;
    logic prev_next;
    ifeb_edge_t mode;
    // decode the two-bit selector into a mode
    always_comb begin
        case (sel)
            2'h1: mode = IFEB_EDGE_RISE;
            2'h2: mode = IFEB_EDGE_FALL;
            2'h3: mode = IFEB_EDGE_BOTH;
            default: mode = IFEB_EDGE_OFF;
        endcase
        prev_next = pin;
    end
    // pulse on the selected transition
    always_comb begin
        case (mode)
            IFEB_EDGE_RISE: hit = pin & ~prev_reg;
            IFEB_EDGE_FALL: hit = ~pin & prev_reg;
            IFEB_EDGE_BOTH: hit = pin ^ prev_reg;
            default: hit = 1'b0;
        endcase
    end
    // previous pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end
endmodule : ifeb_edge_det

//--- design/ifeb_flag_reg.sv
// one byte register with hardware set terms that win over software writes
`timescale 1ns/1ps
module ifeb_flag_reg #(
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] hw_set,
    input wire logic [7:0] hw_clr,
    output logic [7:0] q
);
    logic [7:0] q_next;
    // write, then hardware clear, then hardware set on top
    always_comb begin
        q_next = wr ? wdata : q;
        q_next = q_next & ~hw_clr;
        q_next = (q_next | hw_set) & MASK;
    end
    // storage, cleared at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 8'h00;
        end else begin
            q <= q_next;
        end
    end
endmodule : ifeb_flag_reg

//--- design/ifeb_bank.sv
// interrupt flag and enable bank with apb register access
// Notes on behaviour
// - pin a selector: 00 off, 01 rising, 10 falling, 11 both edges.
// - pin b selector sits in edge bits 3..2, same coding.
// - edge register bits 7..4 read zero.
// - in the grouped variant every source has one enable bit and one request flag.
// - control 0: g0 flag 6, b flag 5, a flag 4, enables 3..1, global 0.
// - control 1: lv flag 7, tb flag 6, g1 flag 4, enables 3, 2, 0.
// - hardware sets flags; software reads and writes the edge, control, group and event enable bits; event status only clears through the clear register.
// - control 0 bit 7 and control 1 bits 5, 1 read zero.
// - sources: two pins, timer matches, time base, low voltage.
// - ungrouped variant puts timer1 p and a matches in group slots.
// - group 0: timer0 a flag 5, p flag 4, enables 1, 0.
// - group 1: timer1 b, a, p flags 6..4, enables 2..0.
// - a set control 0/1 flag raises core_irq only when its enable is one; group member enables gate nothing.
// - global enable low blocks core_irq; event_irq is not gated by it.
`timescale 1ns/1ps
`include "ifeb_consts.svh"
module ifeb_bank #(
    parameter logic GROUPED = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_pin_a,
    input wire logic ext_pin_b,
    input wire logic timer0_match_a,
    input wire logic timer0_match_p,
    input wire logic timer1_match_a,
    input wire logic timer1_match_p,
    input wire logic timer1_match_b,
    input wire logic timebase_tick,
    input wire logic low_voltage_detector,
    input wire logic irq_ack,
    output logic core_irq,
    output logic event_irq
);
    import ifeb_pkg::*;
    ifeb_byte_t edge_q, ctl0_q, ctl1_q, grp0_q, grp1_q, evst_q, even_q;
    ifeb_byte_t ctl0_set, ctl1_set, grp0_set, grp1_set, evst_set, ctl0_clr, evst_clr;
    logic hit_a, hit_b, acc, wr, rd_ok;
    logic wr_edge, wr_ctl0, wr_ctl1, wr_grp0, wr_grp1, wr_even, wr_evclr;
    logic g0_rise, g1_rise, pend;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next, core_irq_next, event_irq_next;

    ////////////////////////////////////////////////////////////////////////
    // apb decode: access phase with one wait cycle, unmapped addresses get pslverr
    assign acc = psel & penable & ~pready;
    assign wr = acc & pwrite & rd_ok;
    assign wr_edge = wr & (paddr == `IFEB_OFF_EDGE);
    assign wr_ctl0 = wr & (paddr == `IFEB_OFF_CTL0);
    assign wr_ctl1 = wr & (paddr == `IFEB_OFF_CTL1);
    assign wr_grp0 = wr & (paddr == `IFEB_OFF_GRP0) & GROUPED;
    assign wr_grp1 = wr & (paddr == `IFEB_OFF_GRP1) & GROUPED;
    assign wr_even = wr & (paddr == `IFEB_OFF_EVEN);
    assign wr_evclr = wr & (paddr == `IFEB_OFF_EVCLR);

    // read mux; unimplemented bits are masked off in each register
    always_comb begin
        rd_ok = 1'b1;
        prdata_next = 32'h0000_0000;
        case (paddr)
            `IFEB_OFF_EDGE: prdata_next[7:0] = edge_q;
            `IFEB_OFF_CTL0: prdata_next[7:0] = ctl0_q;
            `IFEB_OFF_CTL1: prdata_next[7:0] = ctl1_q;
            `IFEB_OFF_GRP0: prdata_next[7:0] = grp0_q;
            `IFEB_OFF_GRP1: prdata_next[7:0] = grp1_q;
            `IFEB_OFF_EVST: prdata_next[7:0] = evst_q;
            `IFEB_OFF_EVEN: prdata_next[7:0] = even_q;
            `IFEB_OFF_EVCLR: prdata_next[7:0] = 8'h00;
            `IFEB_OFF_VARIANT: prdata_next[0] = GROUPED;
            default: rd_ok = 1'b0;
        endcase
        if (!acc || pwrite) begin
            prdata_next = 32'h0000_0000;
        end
        pready_next = acc;
        pslverr_next = acc & ~rd_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // external pin edge detectors
    ifeb_edge_det u_pin_a (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_pin_a),
        .sel(edge_q[1:0]),
        .hit(hit_a)
    );
    ifeb_edge_det u_pin_b (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_pin_b),
        .sel(edge_q[3:2]),
        .hit(hit_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // set terms from sources; group flag follows rising of any member flag
    assign g0_rise = GROUPED & |(grp0_set & ~grp0_q & 8'h30);
    assign g1_rise = GROUPED & |(grp1_set & ~grp1_q & 8'h70);
    always_comb begin
        grp0_set = {2'b00, timer0_match_a, timer0_match_p, 4'h0};
        grp1_set = {1'b0, timer1_match_b, timer1_match_a, timer1_match_p, 4'h0};
        ctl0_set = 8'h00;
        ctl1_set = 8'h00;
        ctl0_set[`IFEB_C0_PA_FL] = hit_a;
        ctl0_set[`IFEB_C0_PB_FL] = hit_b;
        ctl0_set[`IFEB_C0_G0_FL] = GROUPED ? g0_rise : timer1_match_p;
        ctl1_set[`IFEB_C1_G1_FL] = GROUPED ? g1_rise : timer1_match_a;
        ctl1_set[`IFEB_C1_TB_FL] = timebase_tick;
        ctl1_set[`IFEB_C1_LV_FL] = low_voltage_detector;
        ctl0_clr = 8'h00;
        ctl0_clr[`IFEB_C0_EMI] = irq_ack; // core clears global enable on entry
        evst_set = ctl0_set & 8'h70 | {ctl1_set[7:6], 2'b00, ctl1_set[4], 3'b000};
        evst_set[0] = g0_rise | g1_rise;
        evst_clr = wr_evclr ? pwdata[7:0] : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // register storage; hardware set wins over a write in the same cycle
    ifeb_flag_reg #(.MASK(`IFEB_EDGE_MASK)) u_edge (
        .pclk(pclk), .presetn(presetn), .wr(wr_edge), .wdata(pwdata[7:0]),
        .hw_set(8'h00), .hw_clr(8'h00), .q(edge_q)
    );
    ifeb_flag_reg #(.MASK(`IFEB_CTL0_MASK)) u_ctl0 (
        .pclk(pclk), .presetn(presetn), .wr(wr_ctl0), .wdata(pwdata[7:0]),
        .hw_set(ctl0_set), .hw_clr(ctl0_clr), .q(ctl0_q)
    );
    ifeb_flag_reg #(.MASK(`IFEB_CTL1_MASK)) u_ctl1 (
        .pclk(pclk), .presetn(presetn), .wr(wr_ctl1), .wdata(pwdata[7:0]),
        .hw_set(ctl1_set), .hw_clr(8'h00), .q(ctl1_q)
    );
    ifeb_flag_reg #(.MASK(`IFEB_GRP0_MASK)) u_grp0 (
        .pclk(pclk), .presetn(presetn), .wr(wr_grp0), .wdata(pwdata[7:0]),
        .hw_set(GROUPED ? grp0_set : 8'h00), .hw_clr(8'h00), .q(grp0_q)
    );
    ifeb_flag_reg #(.MASK(`IFEB_GRP1_MASK)) u_grp1 (
        .pclk(pclk), .presetn(presetn), .wr(wr_grp1), .wdata(pwdata[7:0]),
        .hw_set(GROUPED ? grp1_set : 8'h00), .hw_clr(8'h00), .q(grp1_q)
    );
    ifeb_flag_reg #(.MASK(8'hFF)) u_evst (
        .pclk(pclk), .presetn(presetn), .wr(1'b0), .wdata(8'h00),
        .hw_set(evst_set), .hw_clr(evst_clr), .q(evst_q)
    );
    ifeb_flag_reg #(.MASK(8'hFF)) u_even (
        .pclk(pclk), .presetn(presetn), .wr(wr_even), .wdata(pwdata[7:0]),
        .hw_set(8'h00), .hw_clr(8'h00), .q(even_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt request: any enabled flag, gated by the global enable
    always_comb begin
        pend = (ctl0_q[`IFEB_C0_PA_FL] & ctl0_q[`IFEB_C0_PA_EN])
             | (ctl0_q[`IFEB_C0_PB_FL] & ctl0_q[`IFEB_C0_PB_EN])
             | (ctl0_q[`IFEB_C0_G0_FL] & ctl0_q[`IFEB_C0_G0_EN])
             | (ctl1_q[`IFEB_C1_G1_FL] & ctl1_q[`IFEB_C1_G1_EN])
             | (ctl1_q[`IFEB_C1_TB_FL] & ctl1_q[`IFEB_C1_TB_EN])
             | (ctl1_q[`IFEB_C1_LV_FL] & ctl1_q[`IFEB_C1_LV_EN]);
        core_irq_next = pend & ctl0_q[`IFEB_C0_EMI];
        event_irq_next = |(evst_q & even_q);
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            core_irq <= 1'b0;
            event_irq <= 1'b0;
        end else begin
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            core_irq <= core_irq_next;
            event_irq <= event_irq_next;
        end
    end
endmodule : ifeb_bank

//--- tb/ifeb_bank_asserts.sv
// port checks for the interrupt flag bank
`timescale 1ns/1ps
`include "ifeb_consts.svh"
module ifeb_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic irq_ack,
    input wire logic core_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a completed read
    sequence rd_done;
        pready && !pwrite;
    endsequence
    ////////////////////////////////////////////////////////////////
    // bus answer timing
    wait_one_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
    // unimplemented bits
    edge_top_zero_a: assert property (rd_done ##0 paddr == `IFEB_OFF_EDGE |->
        prdata[31:4] == 28'h0) else $error("edge select high bits set");
    ctl0_gap_zero_a: assert property (rd_done ##0 paddr == `IFEB_OFF_CTL0 |->
        prdata[31:7] == 25'h0) else $error("control 0 bit 7 set");
    ctl1_gap_zero_a: assert property (rd_done ##0 paddr == `IFEB_OFF_CTL1 |->
        !prdata[5] && !prdata[1]) else $error("control 1 gap bits set");
    // global enable low keeps the core request quiet
    global_off_quiet_a: assert property (pready && pwrite && paddr == `IFEB_OFF_CTL0
        && !pwdata[0] |-> ##2 !core_irq[*2]) else $error("request with global off");
    ack_quiet_a: assert property (irq_ack |-> ##2 !core_irq) else $error("request after entry");
endmodule : ifeb_chk

//--- tb/ifeb_src_model.sv
// model of the event sources and the core's interrupt entry
`timescale 1ns/1ps
module ifeb_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] fire,
    input wire logic ack_en,
    input wire logic core_irq,
    output logic [6:0] evt,
    output logic irq_ack
);
    // each requested event lasts one cycle; entry pulses while a request stands and ack_en is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= 7'h00;
            irq_ack <= 1'b0;
        end else begin
            evt <= fire & ~evt;
            irq_ack <= ack_en & core_irq & ~irq_ack;
        end
    end
endmodule : ifeb_src_model

//--- tb/ifeb_bank_bench.sv
// self-checking bench for the interrupt flag bank
`timescale 1ns/1ps
`include "ifeb_consts.svh"
module ifeb_bank_bench;
    import ifeb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pin_a, pin_b, ack_en, er;
    logic pready, pslverr, irq_ack, core_irq, event_irq;
    logic flat, pready_f, pslverr_f;
    logic [31:0] prdata_f;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] fire, evt;
    int error_cnt = 0;
    int comparisons = 0;
    logic [11:0] offs [5] = '{`IFEB_OFF_EDGE, `IFEB_OFF_CTL0, `IFEB_OFF_CTL1,
        `IFEB_OFF_GRP0, `IFEB_OFF_GRP1};
    ifeb_byte_t msk [5] = '{8'h0F, 8'h7F, 8'hDD, 8'h33, 8'h77};
    ifeb_byte_t g_exp [7] = '{8'h20, 8'h10, 8'h20, 8'h10, 8'h40, 8'h00, 8'h00};
    ifeb_byte_t c1_exp [7] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h10, 8'h40, 8'h80};
    // second copy in the ungrouped variant, selected on the bus by flat
    ifeb_bank #(.GROUPED(1'b0)) uut_flat (.pclk, .presetn, .psel(psel & flat), .penable,
        .pwrite, .paddr, .pwdata, .prdata(prdata_f), .pready(pready_f), .pslverr(pslverr_f),
        .ext_pin_a(pin_a), .ext_pin_b(pin_b), .timer0_match_a(evt[0]),
        .timer0_match_p(evt[1]), .timer1_match_a(evt[2]), .timer1_match_p(evt[3]),
        .timer1_match_b(evt[4]), .timebase_tick(evt[5]), .low_voltage_detector(evt[6]),
        .irq_ack, .core_irq(), .event_irq());
    ifeb_bank uut (.pclk, .presetn, .psel(psel & ~flat), .penable, .pwrite, .paddr,
        .pwdata, .prdata,
        .pready, .pslverr, .ext_pin_a(pin_a), .ext_pin_b(pin_b), .timer0_match_a(evt[0]),
        .timer0_match_p(evt[1]), .timer1_match_a(evt[2]), .timer1_match_p(evt[3]),
        .timer1_match_b(evt[4]), .timebase_tick(evt[5]), .low_voltage_detector(evt[6]),
        .irq_ack, .core_irq, .event_irq);
    ifeb_src_model src (.pclk, .presetn, .fire, .ack_en, .core_irq, .evt, .irq_ack);
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while ((flat ? pready_f : pready) !== 1'b1 && ++n < 40);
        rd = flat ? prdata_f : prdata;
        er = flat ? pslverr_f : pslverr;
        if (n >= 40) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input ifeb_byte_t d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic chk(input logic [11:0] a, input ifeb_byte_t e);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("register %h", a), {24'h0, e}, rd);
    endtask : chk
    task automatic clr;
        for (int k = 4; k >= 0; k--) wr(offs[k], 8'h00);
    endtask : clr
    task automatic pulse(input int i);
        @(posedge pclk);
        fire <= 7'h01 << i;
        @(posedge pclk);
        fire <= 7'h00;
        repeat (3) @(posedge pclk);
    endtask : pulse
    task automatic irqs(input logic [1:0] e);
        repeat (3) @(posedge pclk);
        cmp("core and event irq", {30'h0, e}, {30'h0, core_irq, event_irq});
    endtask : irqs
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, pin_a, pin_b, ack_en} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        fire = 7'h00;
        flat = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 5; k++) chk(offs[k], 8'h00);
        chk(`IFEB_OFF_VARIANT, 8'h01);
        for (int k = 0; k < 5; k++) begin
            wr(offs[k], 8'hFF);
            chk(offs[k], msk[k]);
        end
        clr();
        for (int c = 0; c < 4; c++) begin
            logic [1:0] a, b;
            a = 2'(c);
            b = 2'(3 - c);
            wr(`IFEB_OFF_EDGE, {4'h0, b, a});
            pin_a <= 1'b1;
            pin_b <= 1'b1;
            repeat (4) @(posedge pclk);
            chk(`IFEB_OFF_CTL0, {2'b00, b[0], a[0], 4'h0});
            wr(`IFEB_OFF_CTL0, 8'h00);
            pin_a <= 1'b0;
            pin_b <= 1'b0;
            repeat (4) @(posedge pclk);
            chk(`IFEB_OFF_CTL0, {2'b00, b[1], a[1], 4'h0});
            wr(`IFEB_OFF_CTL0, 8'h00);
        end
        clr();
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            chk(i < 2 ? `IFEB_OFF_GRP0 : `IFEB_OFF_GRP1, g_exp[i]);
            chk(`IFEB_OFF_CTL0, i < 2 ? 8'h40 : 8'h00);
            chk(`IFEB_OFF_CTL1, c1_exp[i]);
            clr();
        end
        pulse(5);
        wr(`IFEB_OFF_CTL0, 8'h01);
        irqs(2'b00);
        wr(`IFEB_OFF_CTL1, 8'h44);
        irqs(2'b10);
        wr(`IFEB_OFF_CTL0, 8'h00);
        irqs(2'b00);
        wr(`IFEB_OFF_CTL0, 8'h01);
        irqs(2'b10);
        ack_en <= 1'b1;
        repeat (4) @(posedge pclk);
        ack_en <= 1'b0;
        irqs(2'b00);
        chk(`IFEB_OFF_CTL0, 8'h00);
        clr();
        wr(`IFEB_OFF_EVCLR, 8'hFF);
        pulse(6);
        chk(`IFEB_OFF_EVST, 8'h80);
        irqs(2'b00);
        wr(`IFEB_OFF_EVEN, 8'h80);
        irqs(2'b01);
        wr(`IFEB_OFF_EVCLR, 8'h80);
        chk(`IFEB_OFF_EVST, 8'h00);
        irqs(2'b00);
        // ungrouped variant: timer1 p and a land directly in the control registers
        flat <= 1'b1;
        wr(`IFEB_OFF_CTL0, 8'h00);
        wr(`IFEB_OFF_CTL1, 8'h00);
        pulse(3);
        chk(`IFEB_OFF_CTL0, 8'h40);
        pulse(2);
        chk(`IFEB_OFF_CTL1, 8'h10);
        wr(`IFEB_OFF_GRP0, 8'hFF);
        chk(`IFEB_OFF_GRP0, 8'h00);
        chk(`IFEB_OFF_VARIANT, 8'h00);
        flat <= 1'b0;
        apb(1'b1, 12'h0FC, 32'hFF);
        cmp("slave error", 32'h1, {31'h0, er});
        apb(1'b0, 12'h0FC, 32'h0);
        cmp("unmapped read", 32'h0, rd);
        report_and_stop();
    end
endmodule : ifeb_bank_bench
bind ifeb_bank ifeb_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .irq_ack, .core_irq);
